// *** edge_div.sv ***
`timescale 1ns/10ps
`default_nettype none
module edge_div
#(
  parameter int RATIO = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic src,
  output logic div_out
);
  localparam int HALF = RATIO / 2;
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;

  if (RATIO < 2 || (RATIO % 2) != 0)
  begin : g_bad_ratio
    $error("Divide ratio must be even and at least two.");
  end

  logic src_prev_r;
  logic [CW-1:0] cnt_r;
  logic div_r;
  wire rise = src & ~src_prev_r;
  wire wrap = (cnt_r == CW'(HALF - 1));

  // Sampled clock: its edges are counted, so it must stay at or below half rate.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      src_prev_r <= 1'b0;
      cnt_r <= '0;
      div_r <= 1'b0;
    end
    else
    begin
      src_prev_r <= src;
      if (rise)
      begin
        cnt_r <= wrap ? '0 : cnt_r + CW'(1);
        if (wrap)
          div_r <= ~div_r;
      end
    end
  end

  assign div_out = div_r;

  property p_div_steady;
    @(posedge clk) disable iff (!rst_n)
    !(rise && wrap) |=> $stable(div_r);
  endproperty
  a_div_steady: assert property (p_div_steady)
    else $error("Divided clock moved without a wrap.");

endmodule
`default_nettype wire

// *** gpio_output_source_mux.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_defines.svh"
module gpio_output_source_mux
  import pin_mux_pkg::*;
#(
  parameter int DIV_RATIO = `DIV_RATIO
)
(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire reg_req_s REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire src_flags_s SRC_FLAGS,
  input wire logic PIN_TWO_DIR_OUT,
  input wire logic PIN_TWO_INVERT,
  input wire logic [4:0] MUTE_PIN_SEL,
  input wire logic [4:0] PIN_ZERO_SEL,
  output logic PIN_TWO_OUT,
  output logic PIN_TWO_OE,
  output logic MUTE_PIN_REG_OUT,
  output logic PIN_ZERO_REG_OUT
);

  logic [7:0] sel_reg_r;
  logic [7:0] lvl_r;
  logic [7:0] rdata_r;
  logic out_r;
  logic oe_r;
  logic mute_r;
  logic pin0_r;
  logic pll_div;
  logic osc_div;
  logic [31:0] src_vec;

  // Register decode.
  wire wr_sel = REG_REQ.wr && (REG_REQ.addr == `OFS_PIN2_SEL);
  wire wr_lvl = REG_REQ.wr && (REG_REQ.addr == `OFS_LEVELS);
  wire rd_sel = REG_REQ.rd && (REG_REQ.addr == `OFS_PIN2_SEL);
  wire rd_lvl = REG_REQ.rd && (REG_REQ.addr == `OFS_LEVELS);
  // Unmapped addresses read as zero.
  wire [7:0] rd_mux = rd_sel ? sel_reg_r :
                      rd_lvl ? lvl_r : 8'h00;

  // Reserved bits are stored for readback but never reach a pin.
  wire [4:0] sel_r = sel_reg_r[`SEL_MSB:0];

  edge_div #(
    .RATIO(DIV_RATIO)
  ) u_pll_div (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .src(SRC_FLAGS.pll_clk),
    .div_out(pll_div)
  );

  edge_div #(
    .RATIO(DIV_RATIO)
  ) u_osc_div (
    .clk(REF_CLK),
    .rst_n(RESET_N),
    .src(SRC_FLAGS.osc_clk),
    .div_out(osc_div)
  );

  // One entry per selector code; unlisted codes stay zero.
  always_comb
  begin
    src_vec = 32'h0000_0000;
    src_vec[`SEL_OFF] = 1'b0;
    src_vec[`SEL_CORE] = SRC_FLAGS.core_pin2;
    src_vec[`SEL_REG] = lvl_r[`LVL_PIN2_BIT];
    src_vec[`SEL_AMUTE_BOTH] =
      SRC_FLAGS.amute_left & SRC_FLAGS.amute_right;
    src_vec[`SEL_AMUTE_L] = SRC_FLAGS.amute_left;
    src_vec[`SEL_AMUTE_R] = SRC_FLAGS.amute_right;
    src_vec[`SEL_CLK_INVALID] = SRC_FLAGS.clk_invalid;
    src_vec[`SEL_SER_OUT] = SRC_FLAGS.serial_audio_out;
    src_vec[`SEL_ANA_MUTE_L] = SRC_FLAGS.ana_mute_left_n;
    src_vec[`SEL_ANA_MUTE_R] = SRC_FLAGS.ana_mute_right_n;
    src_vec[`SEL_PLL_LOCK] = SRC_FLAGS.pll_lock;
    src_vec[`SEL_PUMP_CLK] = SRC_FLAGS.pump_clk;
    src_vec[`SEL_UV_HIGH] = SRC_FLAGS.uv_mute_high;
    src_vec[`SEL_UV_LOW] = SRC_FLAGS.uv_mute_low;
    src_vec[`SEL_PLL_DIV] = pll_div;
    src_vec[`SEL_OSC_DIV] = osc_div;
    src_vec[`SEL_IMP_L] = SRC_FLAGS.imp_left;
    src_vec[`SEL_IMP_R] = SRC_FLAGS.imp_right;
    src_vec[`SEL_UV_PROTECT] =
      SRC_FLAGS.undervoltage_protect_n;
    src_vec[`SEL_OFFSET_CAL] = SRC_FLAGS.offset_cal;
    src_vec[`SEL_CLK_CHANGE] = SRC_FLAGS.clk_changing;
    src_vec[`SEL_CLK_MISSING] = SRC_FLAGS.clk_missing;
    src_vec[`SEL_CLK_HALT] = SRC_FLAGS.clk_halt;
    src_vec[`SEL_BOOT_DONE] = SRC_FLAGS.boot_done;
    src_vec[`SEL_PUMP_VALID] = SRC_FLAGS.pump_valid_n;
  end

  wire pin2_nxt = src_vec[sel_r] ^ PIN_TWO_INVERT;
  wire mute_nxt = (MUTE_PIN_SEL == `SEL_REG) &
                  lvl_r[`LVL_MUTE_BIT];
  wire pin0_nxt = (PIN_ZERO_SEL == `SEL_REG) &
                  lvl_r[`LVL_PIN0_BIT];

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      sel_reg_r <= `RST_PIN2_SEL;
      lvl_r <= `RST_LEVELS;
    end
    else
    begin
      if (wr_sel)
        sel_reg_r <= REG_REQ.wdata;
      if (wr_lvl)
        lvl_r <= REG_REQ.wdata;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      rdata_r <= 8'h00;
      out_r <= 1'b0;
      oe_r <= 1'b0;
      mute_r <= 1'b0;
      pin0_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rd_mux;
      out_r <= pin2_nxt;
      oe_r <= PIN_TWO_DIR_OUT;
      mute_r <= mute_nxt;
      pin0_r <= pin0_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign PIN_TWO_OUT = out_r;
  assign PIN_TWO_OE = oe_r;
  assign MUTE_PIN_REG_OUT = mute_r;
  assign PIN_ZERO_REG_OUT = pin0_r;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_sel_write;
    wr_sel |=> sel_r == $past(REG_REQ.wdata[4:0]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("Selector did not take written value.");

  // Own disable term: the default one would switch this check off.
  property p_sel_reset;
    @(posedge REF_CLK) disable iff (1'b0)
    $rose(RESET_N) |-> sel_reg_r == 8'h00 && lvl_r == 8'h00
      && !PIN_TWO_OUT && !PIN_TWO_OE;
  endproperty
  a_sel_reset: assert property (p_sel_reset)
    else $error("Selector not zero after reset.");

  property p_oe_follows;
    PIN_TWO_DIR_OUT |=> PIN_TWO_OE ##0 $past(PIN_TWO_DIR_OUT);
  endproperty
  a_oe_follows: assert property (p_oe_follows)
    else $error("Pin enable did not follow direction.");

  property p_oe_off;
    !PIN_TWO_DIR_OUT |=> !PIN_TWO_OE;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("Pin enabled while direction is input.");

  property p_off_low;
    (sel_r == `SEL_OFF) && !PIN_TWO_INVERT |=> !PIN_TWO_OUT;
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("Off code did not drive low.");

  property p_core;
    sel_r == `SEL_CORE
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.core_pin2 ^ PIN_TWO_INVERT);
  endproperty
  a_core: assert property (p_core)
    else $error("Core output not routed.");

  property p_reg_level;
    sel_r == `SEL_REG
      |=> PIN_TWO_OUT == $past(lvl_r[5] ^ PIN_TWO_INVERT);
  endproperty
  a_reg_level: assert property (p_reg_level)
    else $error("Software level not driven.");

  property p_level_write;
    wr_lvl ##1 (sel_r == `SEL_REG) && !PIN_TWO_INVERT
      |=> PIN_TWO_OUT == $past(REG_REQ.wdata[5], 2);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("Written level did not reach pin.");

  property p_amute_both;
    sel_r == `SEL_AMUTE_BOTH
      |=> PIN_TWO_OUT == $past((SRC_FLAGS.amute_left
          & SRC_FLAGS.amute_right) ^ PIN_TWO_INVERT);
  endproperty
  a_amute_both: assert property (p_amute_both)
    else $error("Both-channel mute flag wrong.");

  property p_amute_r;
    sel_r == `SEL_AMUTE_R
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.amute_right ^ PIN_TWO_INVERT);
  endproperty
  a_amute_r: assert property (p_amute_r)
    else $error("Right mute flag wrong.");

  property p_amute_l;
    sel_r == `SEL_AMUTE_L
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.amute_left ^ PIN_TWO_INVERT);
  endproperty
  a_amute_l: assert property (p_amute_l)
    else $error("Left mute flag wrong.");

  property p_ser_out;
    sel_r == `SEL_SER_OUT
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.serial_audio_out
          ^ PIN_TWO_INVERT);
  endproperty
  a_ser_out: assert property (p_ser_out)
    else $error("Serial data not routed.");

  property p_ana_mute;
    sel_r == `SEL_ANA_MUTE_L
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.ana_mute_left_n
          ^ PIN_TWO_INVERT);
  endproperty
  a_ana_mute: assert property (p_ana_mute)
    else $error("Analog mute flag wrong.");

  property p_pump_clk;
    sel_r == `SEL_PUMP_CLK
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.pump_clk ^ PIN_TWO_INVERT);
  endproperty
  a_pump_clk: assert property (p_pump_clk)
    else $error("Pump clock not routed.");

  property p_pll_lock;
    sel_r == `SEL_PLL_LOCK
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.pll_lock ^ PIN_TWO_INVERT);
  endproperty
  a_pll_lock: assert property (p_pll_lock)
    else $error("Lock flag not routed.");

  property p_uv_low;
    sel_r == `SEL_UV_LOW
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.uv_mute_low ^ PIN_TWO_INVERT);
  endproperty
  a_uv_low: assert property (p_uv_low)
    else $error("Undervoltage flag wrong.");

  property p_pll_div;
    sel_r == `SEL_PLL_DIV
      |=> PIN_TWO_OUT == $past(pll_div ^ PIN_TWO_INVERT);
  endproperty
  a_pll_div: assert property (p_pll_div)
    else $error("Divided clock not routed.");

  property p_osc_div;
    sel_r == `SEL_OSC_DIV
      |=> PIN_TWO_OUT == $past(osc_div ^ PIN_TWO_INVERT);
  endproperty
  a_osc_div: assert property (p_osc_div)
    else $error("Oscillator clock not routed.");

  property p_imp;
    sel_r == `SEL_IMP_R
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.imp_right ^ PIN_TWO_INVERT);
  endproperty
  a_imp: assert property (p_imp)
    else $error("Impedance flag wrong.");

  property p_uvp;
    sel_r == `SEL_UV_PROTECT
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.undervoltage_protect_n
          ^ PIN_TWO_INVERT);
  endproperty
  a_uvp: assert property (p_uvp)
    else $error("Protect flag wrong.");

  property p_clk_halt;
    sel_r == `SEL_CLK_HALT
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.clk_halt ^ PIN_TWO_INVERT);
  endproperty
  a_clk_halt: assert property (p_clk_halt)
    else $error("Halt flag wrong.");

  property p_pump_valid;
    sel_r == `SEL_PUMP_VALID
      |=> PIN_TWO_OUT == $past(SRC_FLAGS.pump_valid_n
          ^ PIN_TWO_INVERT);
  endproperty
  a_pump_valid: assert property (p_pump_valid)
    else $error("Pump valid flag wrong.");

  property p_mute_reg;
    MUTE_PIN_SEL == `SEL_REG |=> MUTE_PIN_REG_OUT == $past(lvl_r[4]);
  endproperty
  a_mute_reg: assert property (p_mute_reg)
    else $error("Mute level not driven.");

  property p_pin0_reg;
    PIN_ZERO_SEL == `SEL_REG |=> PIN_ZERO_REG_OUT == $past(lvl_r[3]);
  endproperty
  a_pin0_reg: assert property (p_pin0_reg)
    else $error("Pin zero level not driven.");

  property p_unassigned;
    (sel_r inside {5'h0c, 5'h0d, 5'h16, [5'h1c:5'h1f]})
      && !PIN_TWO_INVERT |=> !PIN_TWO_OUT;
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("Unassigned code not low.");

  property p_reserved;
    sel_reg_r[7:5] != 3'b000 && (sel_r == `SEL_OFF)
      && !PIN_TWO_INVERT |=> !PIN_TWO_OUT;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("Reserved bits changed pin.");

  property p_invert;
    (sel_r == `SEL_OFF) && PIN_TWO_INVERT |=> PIN_TWO_OUT;
  endproperty
  a_invert: assert property (p_invert)
    else $error("Inversion not applied.");

  property p_readback;
    rd_sel |=> REG_RDATA == $past(sel_reg_r);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Selector readback wrong.");

  c_reg_drive: cover property (sel_r == `SEL_REG ##1 PIN_TWO_OUT);
  c_inverted: cover property (PIN_TWO_INVERT && PIN_TWO_OE);
  c_pll_div: cover property (sel_r == `SEL_PLL_DIV ##1 $rose(PIN_TWO_OUT));
  c_mute_reg: cover property (MUTE_PIN_REG_OUT);
  c_level_write: cover property (wr_lvl ##1 sel_r == `SEL_REG);

endmodule
`default_nettype wire

// *** pin_mux_defines.svh ***
// Behaviour
// - Eight-bit selector register, five select bits, read-write, resets zero.
// - Pin driven only while direction is output.
// - Code 0 drives low; 1 routes core.
// - Code 2 drives software level bit five.
// - Codes 3-5: both, left, right auto-mute.
// - Code 7 routes serial audio data out.
// - Codes 8, 9: analog mute flags, active low.
// - Code 10 lock flag, 11 pump clock.
// - Codes 14, 15: mute-pin undervoltage flags.
// - Codes 16, 17: PLL, oscillator clocks by four.
// - Codes 18, 19: impedance-sense flags left, right.
// - Code 20: undervoltage protect flag, low active.
// - Codes 23-25: clock changing, missing, halt.
// - Code 26 boot done; 27 pump valid low.
// - Level bit five drives pin two at code 2.
// - Level bit four drives mute pin at 2.
// - Level bit three drives pin zero at 2.
// - Invert bit flips pin two for any source.
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

`define OFS_PIN2_SEL 8'h55
`define OFS_LEVELS 8'h56
`define RST_PIN2_SEL 8'h00
`define RST_LEVELS 8'h00
`define SEL_MSB 4
`define LVL_PIN2_BIT 5
`define LVL_MUTE_BIT 4
`define LVL_PIN0_BIT 3
`define DIV_RATIO 4

`define SEL_OFF 5'h00
`define SEL_CORE 5'h01
`define SEL_REG 5'h02
`define SEL_AMUTE_BOTH 5'h03
`define SEL_AMUTE_L 5'h04
`define SEL_AMUTE_R 5'h05
`define SEL_CLK_INVALID 5'h06
`define SEL_SER_OUT 5'h07
`define SEL_ANA_MUTE_L 5'h08
`define SEL_ANA_MUTE_R 5'h09
`define SEL_PLL_LOCK 5'h0a
`define SEL_PUMP_CLK 5'h0b
`define SEL_UV_HIGH 5'h0e
`define SEL_UV_LOW 5'h0f
`define SEL_PLL_DIV 5'h10
`define SEL_OSC_DIV 5'h11
`define SEL_IMP_L 5'h12
`define SEL_IMP_R 5'h13
`define SEL_UV_PROTECT 5'h14
`define SEL_OFFSET_CAL 5'h15
`define SEL_CLK_CHANGE 5'h17
`define SEL_CLK_MISSING 5'h18
`define SEL_CLK_HALT 5'h19
`define SEL_BOOT_DONE 5'h1a
`define SEL_PUMP_VALID 5'h1b

`endif

// *** pin_mux_pkg.sv ***
package pin_mux_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic core_pin2;
    logic amute_left;
    logic amute_right;
    logic clk_invalid;
    logic serial_audio_out;
    logic ana_mute_left_n;
    logic ana_mute_right_n;
    logic pll_lock;
    logic pump_clk;
    logic uv_mute_high;
    logic uv_mute_low;
    logic pll_clk;
    logic osc_clk;
    logic imp_left;
    logic imp_right;
    logic undervoltage_protect_n;
    logic offset_cal;
    logic clk_changing;
    logic clk_missing;
    logic clk_halt;
    logic boot_done;
    logic pump_valid_n;
  } src_flags_s;

endpackage

// *** pin_watch.sv ***
`timescale 1ns/10ps
`default_nettype none
// External circuit on pin two, with a weak pull-down on the line.
module pin_watch
(
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  // The line falls to the pull-down whenever the pin is not driven.
  assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import pin_mux_pkg::*;
;
  localparam int DIV = 4;
  logic ref_clk;
  logic reset_n;
  reg_req_s req;
  src_flags_s flags;
  logic dir_out;
  logic inv;
  logic [4:0] msel;
  logic [4:0] zsel;
  logic [7:0] rdata;
  logic pin_two_out;
  logic pin_two_oe;
  logic mute_out;
  logic zero_out;
  logic pin_level;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [4:0] sel_tab [28] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07,
    5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h14, 5'h15,
    5'h17, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h0c, 5'h0d, 5'h16, 5'h1c, 5'h1d,
    5'h1e, 5'h1f};
  // Flag bit routed by each code, or -1 where the pin must stay low.
  int pos_tab [28] = '{-1, 21, 20, 19, 18, 17, 16, 15, 14, 13, 12, 11, 8,
    7, 6, 5, 4, 3, 2, 1, 0, -1, -1, -1, -1, -1, -1, -1};

  gpio_output_source_mux #(.DIV_RATIO(DIV)) dut_u
  (
    .REF_CLK(ref_clk),
    .RESET_N(reset_n),
    .REG_REQ(req),
    .REG_RDATA(rdata),
    .SRC_FLAGS(flags),
    .PIN_TWO_DIR_OUT(dir_out),
    .PIN_TWO_INVERT(inv),
    .MUTE_PIN_SEL(msel),
    .PIN_ZERO_SEL(zsel),
    .PIN_TWO_OUT(pin_two_out),
    .PIN_TWO_OE(pin_two_oe),
    .MUTE_PIN_REG_OUT(mute_out),
    .PIN_ZERO_REG_OUT(zero_out)
  );

  pin_watch watch_u
  (
    .pin_out(pin_two_out),
    .pin_oe(pin_two_oe),
    .pin_level(pin_level)
  );

  always #4 ref_clk = ~ref_clk;

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic apply(input src_flags_s f, input logic exp);
    @(posedge ref_clk);
    flags <= f;
    @(posedge ref_clk);
    #1;
    chk({7'h00, pin_level}, {7'h00, exp});
  endtask

  task automatic lvl(input logic [7:0] v, input logic [4:0] m,
    input logic [4:0] z, input logic [2:0] exp);
    reg_wr(8'h56, v);
    @(posedge ref_clk);
    msel <= m;
    zsel <= z;
    @(posedge ref_clk);
    #1;
    chk({5'h00, pin_level, mute_out, zero_out}, {5'h00, exp});
  endtask

  task automatic div_chk(input int pos);
    int last;
    int cnt;
    logic prev;
    last = -1;
    cnt = 0;
    prev = pin_level;
    for (int i = 0; i < 48; i++)
    begin
      @(posedge ref_clk);
      flags[pos] <= ~flags[pos];
      #1;
      if (pin_level !== prev)
      begin
        if (last >= 0)
          chk(8'(i - last), 8'(DIV));
        last = i;
        cnt++;
        prev = pin_level;
      end
    end
    chk(8'(cnt >= 8), 8'h01);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    src_flags_s f;
    logic [7:0] d;
    ref_clk = 1'b0;
    reset_n = 1'b0;
    req = '0;
    flags = '0;
    dir_out = 1'b1;
    inv = 1'b0;
    msel = 5'h00;
    zsel = 5'h00;
    repeat (8) @(posedge ref_clk);
    #1;
    chk({4'h0, pin_two_out, pin_two_oe, mute_out, zero_out}, 8'h00);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    reg_rd(8'h55, d);
    chk(d, 8'h00);
    reg_rd(8'h56, d);
    chk(d, 8'h00);
    for (int i = 0; i < 28; i++)
    begin
      reg_wr(8'h55, {3'h0, sel_tab[i]});
      f = (pos_tab[i] >= 0) ? src_flags_s'(22'h1 << pos_tab[i]) : '1;
      apply(f, pos_tab[i] >= 0);
      apply(~f, 1'b0);
    end
    reg_wr(8'h55, 8'he3);
    reg_rd(8'h55, d);
    chk(d, 8'he3);
    f = '0;
    f.amute_left = 1'b1;
    f.amute_right = 1'b1;
    apply(f, 1'b1);
    f.amute_right = 1'b0;
    apply(f, 1'b0);
    reg_wr(8'h54, 8'h02);
    reg_rd(8'h54, d);
    chk(d, 8'h00);
    reg_rd(8'h55, d);
    chk(d, 8'he3);
    reg_wr(8'h55, 8'he0);
    apply('1, 1'b0);
    reg_wr(8'h55, 8'h02);
    lvl(8'h20, 5'h02, 5'h02, 3'b100);
    lvl(8'hdf, 5'h02, 5'h02, 3'b011);
    lvl(8'h18, 5'h03, 5'h01, 3'b000);
    reg_rd(8'h56, d);
    chk(d, 8'h18);
    lvl(8'h20, 5'h00, 5'h00, 3'b100);
    @(posedge ref_clk);
    dir_out <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({6'h00, pin_two_oe, pin_level}, 8'h00);
    @(posedge ref_clk);
    dir_out <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({6'h00, pin_two_oe, pin_level}, 8'h03);
    reg_wr(8'h55, 8'h00);
    @(posedge ref_clk);
    inv <= 1'b1;
    apply('0, 1'b1);
    reg_wr(8'h55, 8'h0c);
    apply('1, 1'b1);
    @(posedge ref_clk);
    inv <= 1'b0;
    reg_wr(8'h55, 8'h10);
    apply('0, 1'b0);
    div_chk(10);
    reg_wr(8'h55, 8'h11);
    apply('0, 1'b0);
    div_chk(9);
    lvl(8'hdf, 5'h02, 5'h02, 3'b011);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({5'h00, pin_two_out, mute_out, zero_out}, 8'h00);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    reg_rd(8'h55, d);
    chk(d, 8'h00);
    reg_rd(8'h56, d);
    chk(d, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
